// ### verilog/panel_lamp_key.sv
/*
  Front-panel lamp and key logic of a servo-output process controller:
  status lamps, manual motor drive, key actions, screen navigation and a
  small AXI4-Lite register file.
  Assumes state inputs from the control and program sequencer and debounced
  key levels, all synchronous to CORE_CLK_I.
*/
`timescale 1ns/100ps
// Function
// - Run lamp steady while control runs
// - Run lamp blinks during start delay
// - Pause lamp steady on ordinary program hold
// - Pause lamp blinks on input error pause
// - Hand lamp blinks in manual operation
// - Fix lamp lit in fixed-setpoint mode only
// - Pattern-by-inputs lamp when inputs select
// - Link lamp lit in communication mode
// - Tuning lamp steady standby, blinks executing
// - Open and close lamps mirror motor outputs
// - Event and external-output lamps follow activity
// - Down key closes motor or decrements
// - Up key opens motor or increments
// - Step key bumps pending step, commit adopts
// - Pattern key bumps pending pattern, commit adopts
// - Commit combos hold/advance on screens 0-1..0-6
// - Measured value shows error on input error
// - Fixed mode step field dashes, blank running
// - Group key changes group or returns top
// - Edited value stored only on commit
module panel_lamp_key #(
  parameter int BLINK_HALF_CYC = lamp_key_pkg::BLINK_HALF_CYC
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_B_I,
  // Controller state
  input wire logic CTRL_RUN_I,
  input wire logic START_DELAY_I,
  input wire logic PAUSE_I,
  input wire logic ERR_PAUSE_I,
  input wire logic MANUAL_I,
  input wire logic FIX_MODE_I,
  input wire logic PAT_BY_INPUTS_I,
  input wire logic LINK_MODE_I,
  input wire logic TUNE_STANDBY_I,
  input wire logic TUNE_EXEC_I,
  input wire logic INPUT_ERR_I,
  input wire logic CTRL_OPEN_I,
  input wire logic CTRL_CLOSE_I,
  input wire logic [2:0] EVENT_I,
  input wire logic [4:0] EXTERNAL_OUT_I,
  // Front keys (levels, high while pressed)
  input wire logic [lamp_key_pkg::KEY_N-1:0] KEY_I,
  // Lamps
  output logic RUN_LAMP_O,
  output logic PAUSE_LAMP_O,
  output logic HAND_OPERATION_LAMP_O,
  output logic FIX_LAMP_O,
  output logic PATTERN_BY_INPUTS_LAMP_O,
  output logic LINK_MODE_LAMP_O,
  output logic SELF_TUNING_LAMP_O,
  output logic OPEN_LAMP_O,
  output logic CLOSE_LAMP_O,
  output logic [2:0] EVENT_LAMP_O,
  output logic [4:0] EXTERNAL_OUTPUT_LAMP_O,
  // Motor outputs and key actions
  output logic OPEN_MOTOR_O,
  output logic CLOSE_MOTOR_O,
  output logic HOLD_OP_O,
  output logic STEP_ADVANCE_OP_O,
  // Display control
  output logic MV_SHOW_ERR_O,
  output lamp_key_pkg::step_field_t STEP_FIELD_O,
  output logic [2:0] SCREEN_GROUP_O,
  output logic [3:0] SCREEN_INDEX_O,
  output logic [4:0] START_STEP_O,
  output logic [4:0] START_PAT_O,
  output logic [15:0] EDIT_VALUE_O,
  // AXI4-Lite slave
  input wire logic [lamp_key_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [lamp_key_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I
);
  import lamp_key_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic [KEY_N-1:0] press; // One-cycle key press pulses
  logic blink; // Shared blink phase
  logic [LAMP_N-1:0] lamp_r; // Registered lamp image
  logic [LAMP_N-1:0] lamp_nxt; // Next lamp image
  logic open_nxt; // Next open motor state
  logic close_nxt; // Next close motor state
  logic combo_scr; // Screen allows commit combos
  logic hold_combo; // Commit plus pattern
  logic step_combo; // Commit plus step
  logic commit_plain; // Commit alone
  logic [4:0] pend_step_r; // Pending start step
  logic [4:0] pend_pat_r; // Pending start pattern
  logic [15:0] edit_pend_r; // Value being edited
  logic [ADDR_W-1:0] aw_addr_r; // Latched write address
  logic aw_have_r; // Write address held
  logic [31:0] w_data_r; // Latched write data
  logic [3:0] w_strb_r; // Latched byte strobes
  logic w_have_r; // Write data held
  logic aw_hs; // Address handshake
  logic w_hs; // Data handshake
  logic do_write; // Apply held write
  logic edit_wr; // Write hits edit register
  logic [31:0] rd_mux; // Read data selection
  logic rd_hit; // Read address mapped

  // ****************************************
  // Helpers
  // ****************************************
  key_edge #(
    .W(KEY_N)
  ) u_keys (
    .clk_i(CORE_CLK_I),
    .rst_b_i(RST_B_I),
    .level_i(KEY_I),
    .rise_o(press)
  );

  blink_timebase #(
    .HALF_CYC(BLINK_HALF_CYC)
  ) u_blink (
    .clk_i(CORE_CLK_I),
    .rst_b_i(RST_B_I),
    .phase_o(blink)
  );

  // ****************************************
  // Lamps and motor outputs
  // ****************************************
  // Motor drive: keys in manual, controller otherwise
  always_comb begin
    if (MANUAL_I) begin
      close_nxt = KEY_I[KEY_DOWN] & ~KEY_I[KEY_UP];
      open_nxt = KEY_I[KEY_UP] & ~KEY_I[KEY_DOWN];
    end else begin
      close_nxt = CTRL_CLOSE_I & ~CTRL_OPEN_I;
      open_nxt = CTRL_OPEN_I & ~CTRL_CLOSE_I;
    end
  end

  // Lamp image from controller state
  always_comb begin
    lamp_nxt = '0;
    // run lamp; blink in start delay
    lamp_nxt[LAMP_RUN] = START_DELAY_I ? blink : CTRL_RUN_I;
    lamp_nxt[LAMP_PAUSE] = ERR_PAUSE_I ? blink : (PAUSE_I & ~FIX_MODE_I);
    lamp_nxt[LAMP_HAND] = MANUAL_I & blink;
    lamp_nxt[LAMP_FIX] = FIX_MODE_I;
    lamp_nxt[LAMP_PAT_IN] = PAT_BY_INPUTS_I;
    lamp_nxt[LAMP_LINK] = LINK_MODE_I;
    lamp_nxt[LAMP_TUNE] = TUNE_EXEC_I ? blink : TUNE_STANDBY_I;
    lamp_nxt[LAMP_OPEN] = open_nxt;
    lamp_nxt[LAMP_CLOSE] = close_nxt;
    lamp_nxt[LAMP_EV_LSB +: 3] = EVENT_I;
    lamp_nxt[LAMP_XOUT_LSB +: 5] = EXTERNAL_OUT_I;
    lamp_nxt[LAMP_MV_ERR] = INPUT_ERR_I;
  end

  // Register lamps and motor outputs
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      lamp_r <= '0;
      OPEN_MOTOR_O <= 1'b0;
      CLOSE_MOTOR_O <= 1'b0;
    end else begin
      lamp_r <= lamp_nxt;
      OPEN_MOTOR_O <= open_nxt;
      CLOSE_MOTOR_O <= close_nxt;
    end
  end

  assign RUN_LAMP_O = lamp_r[LAMP_RUN];
  assign PAUSE_LAMP_O = lamp_r[LAMP_PAUSE];
  assign HAND_OPERATION_LAMP_O = lamp_r[LAMP_HAND];
  assign FIX_LAMP_O = lamp_r[LAMP_FIX];
  assign PATTERN_BY_INPUTS_LAMP_O = lamp_r[LAMP_PAT_IN];
  assign LINK_MODE_LAMP_O = lamp_r[LAMP_LINK];
  assign SELF_TUNING_LAMP_O = lamp_r[LAMP_TUNE];
  assign OPEN_LAMP_O = lamp_r[LAMP_OPEN];
  assign CLOSE_LAMP_O = lamp_r[LAMP_CLOSE];
  assign EVENT_LAMP_O = lamp_r[LAMP_EV_LSB +: 3];
  assign EXTERNAL_OUTPUT_LAMP_O = lamp_r[LAMP_XOUT_LSB +: 5];
  assign MV_SHOW_ERR_O = lamp_r[LAMP_MV_ERR];

  // ****************************************
  // Key actions
  // ****************************************
  // combos only on basic group screens 1..6
  assign combo_scr = (SCREEN_GROUP_O == 3'h0) && (SCREEN_INDEX_O >= COMBO_SCR_FIRST) &&
                     (SCREEN_INDEX_O <= COMBO_SCR_LAST);
  assign hold_combo = combo_scr & KEY_I[KEY_COMMIT] & KEY_I[KEY_PAT] &
                      (press[KEY_COMMIT] | press[KEY_PAT]);
  assign step_combo = combo_scr & KEY_I[KEY_COMMIT] & KEY_I[KEY_STEP] &
                      (press[KEY_COMMIT] | press[KEY_STEP]);
  assign commit_plain = press[KEY_COMMIT] & ~hold_combo & ~step_combo;

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      HOLD_OP_O <= 1'b0;
      STEP_ADVANCE_OP_O <= 1'b0;
    end else begin
      HOLD_OP_O <= hold_combo;
      STEP_ADVANCE_OP_O <= step_combo;
    end
  end

  // Start step and pattern selection, only in reset state
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pend_step_r <= START_RST;
      pend_pat_r <= START_RST;
      START_STEP_O <= START_RST;
      START_PAT_O <= START_RST;
    end else if (!CTRL_RUN_I) begin
      if (press[KEY_STEP] && !KEY_I[KEY_COMMIT]) begin
        pend_step_r <= (pend_step_r == STEP_MAX) ? START_RST : pend_step_r + 5'h01;
      end
      if (press[KEY_PAT] && !KEY_I[KEY_COMMIT]) begin
        pend_pat_r <= (pend_pat_r == PAT_MAX) ? START_RST : pend_pat_r + 5'h01;
      end
      if (commit_plain) begin
        START_STEP_O <= pend_step_r;
        START_PAT_O <= pend_pat_r;
      end
    end
  end

  // Edited value: bus load, key steps, commit stores
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      edit_pend_r <= EDIT_RST;
      EDIT_VALUE_O <= EDIT_RST;
    end else begin
      if (edit_wr) begin
        // Bus write into the pending value, per byte lane
        if (w_strb_r[0]) begin
          edit_pend_r[7:0] <= w_data_r[7:0];
        end
        if (w_strb_r[1]) begin
          edit_pend_r[15:8] <= w_data_r[15:8];
        end
      end else if (!MANUAL_I && press[KEY_UP] && !press[KEY_DOWN]) begin
        edit_pend_r <= edit_pend_r + 16'h0001;
      end else if (!MANUAL_I && press[KEY_DOWN] && !press[KEY_UP]) begin
        edit_pend_r <= edit_pend_r - 16'h0001;
      end
      if (commit_plain) begin
        EDIT_VALUE_O <= edit_pend_r;
      end
    end
  end

  // Screen navigation
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      SCREEN_GROUP_O <= 3'h0;
      SCREEN_INDEX_O <= 4'h0;
    end else if (press[KEY_GROUP]) begin
      // setup screens off top return to top; basic group or top moves on
      SCREEN_INDEX_O <= 4'h0;
      if ((SCREEN_GROUP_O == 3'h0) || (SCREEN_INDEX_O == 4'h0)) begin
        SCREEN_GROUP_O <= (SCREEN_GROUP_O == GROUP_LAST) ? 3'h0 : SCREEN_GROUP_O + 3'h1;
      end
    end else if (press[KEY_SCREEN]) begin
      // Next screen in the group
      SCREEN_INDEX_O <= (SCREEN_INDEX_O == SCR_LAST) ? 4'h0 : SCREEN_INDEX_O + 4'h1;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      STEP_FIELD_O <= STEP_SHOW_NUM;
    end else if (!FIX_MODE_I) begin
      STEP_FIELD_O <= STEP_SHOW_NUM;
    end else if (CTRL_RUN_I) begin
      STEP_FIELD_O <= STEP_SHOW_BLANK;
    end else begin
      STEP_FIELD_O <= STEP_SHOW_DASH;
    end
  end

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  assign aw_hs = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
  assign w_hs = S_AXI_WVALID_I & S_AXI_WREADY_O;
  assign do_write = aw_have_r & w_have_r & ~S_AXI_BVALID_O;
  assign edit_wr = do_write && (aw_addr_r == OFS_EDIT);

  // Address and data latch independently, in either order
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      S_AXI_AWREADY_O <= 1'b0;
      S_AXI_WREADY_O <= 1'b0;
    end else begin
      if (aw_hs) begin
        aw_addr_r <= S_AXI_AWADDR_I;
      end
      if (w_hs) begin
        w_data_r <= S_AXI_WDATA_I;
        w_strb_r <= S_AXI_WSTRB_I;
      end
      aw_have_r <= ~do_write & (aw_have_r | aw_hs);
      w_have_r <= ~do_write & (w_have_r | w_hs);
      S_AXI_AWREADY_O <= ~(~do_write & (aw_have_r | aw_hs));
      S_AXI_WREADY_O <= ~(~do_write & (w_have_r | w_hs));
    end
  end

  // Write response; unmapped addresses decode-error
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID_O <= 1'b1;
      case (aw_addr_r)
        OFS_STATUS, OFS_EDIT, OFS_STORED, OFS_START, OFS_SCREEN: begin
          S_AXI_BRESP_O <= RESP_OKAY;
        end
        default: begin
          S_AXI_BRESP_O <= RESP_DECERR;
        end
      endcase
    end else if (S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  // Read data selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (S_AXI_ARADDR_I)
      OFS_STATUS: begin
        rd_mux[LAMP_N-1:0] = lamp_r;
        rd_mux[STAT_STEP_FLD_LSB +: 2] = STEP_FIELD_O;
      end
      OFS_EDIT: begin
        rd_mux[15:0] = edit_pend_r;
      end
      OFS_STORED: begin
        rd_mux[15:0] = EDIT_VALUE_O;
      end
      OFS_START: begin
        rd_mux[START_PEND_STEP_LSB +: 5] = pend_step_r;
        rd_mux[START_PEND_PAT_LSB +: 5] = pend_pat_r;
        rd_mux[START_STEP_LSB +: 5] = START_STEP_O;
        rd_mux[START_PAT_LSB +: 5] = START_PAT_O;
      end
      OFS_SCREEN: begin
        rd_mux[SCR_IDX_LSB +: 4] = SCREEN_INDEX_O;
        rd_mux[SCR_GROUP_LSB +: 3] = SCREEN_GROUP_O;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // One read at a time; ready drops while data is out
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h0000_0000;
      S_AXI_RRESP_O <= RESP_OKAY;
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O <= rd_mux;
      S_AXI_RRESP_O <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_ARREADY_O <= 1'b1;
    end else if (!S_AXI_RVALID_O) begin
      S_AXI_ARREADY_O <= 1'b1;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);

  a_run_lamp_steady: assert property (
    CTRL_RUN_I && !START_DELAY_I |=> RUN_LAMP_O) else $error("run lamp not lit");
  a_run_lamp_blink: assert property (
    START_DELAY_I |=> RUN_LAMP_O == $past(blink)) else $error("run lamp not blinking");
  a_pause_lamp_err: assert property (
    ERR_PAUSE_I ##1 ERR_PAUSE_I && $changed(blink) |=> $changed(PAUSE_LAMP_O))
    else $error("pause lamp blink broken");
  a_fix_lamp_mode: assert property (
    ##1 FIX_LAMP_O == $past(FIX_MODE_I)) else $error("fix lamp wrong");
  a_tune_lamp_state: assert property (
    TUNE_STANDBY_I && !TUNE_EXEC_I |=> SELF_TUNING_LAMP_O) else $error("tune lamp dark");
  a_open_lamp_mirror: assert property (
    OPEN_LAMP_O == OPEN_MOTOR_O && CLOSE_LAMP_O == CLOSE_MOTOR_O &&
    ($past(MANUAL_I) || OPEN_LAMP_O == $past(CTRL_OPEN_I && !CTRL_CLOSE_I)))
    else $error("motor lamps differ from outputs");
  a_manual_close_key: assert property (
    MANUAL_I && KEY_I[KEY_DOWN] && !KEY_I[KEY_UP] |=> CLOSE_MOTOR_O && !OPEN_MOTOR_O)
    else $error("down key did not close");
  a_commit_stores_edit: assert property (
    !commit_plain |=> $stable(EDIT_VALUE_O)) else $error("edit stored without commit");
  a_hold_combo_screen: assert property (
    HOLD_OP_O |-> $past(combo_scr)) else $error("hold op off combo screen");
  a_step_field_fix: assert property (
    FIX_MODE_I && !CTRL_RUN_I |=> STEP_FIELD_O == STEP_SHOW_DASH)
    else $error("step field not dashed");
endmodule

// ### verilog/lamp_key_pkg.sv
/*
  Shared constants for the front-panel lamp and key logic: timing counts,
  register offsets, field positions, reset values and enumerations.
  Assumes a 125 MHz core clock and a 32-bit AXI4-Lite register bus.
*/
package lamp_key_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYC = (BLINK_HALF_MS * 1000000) / CLK_PERIOD_NS;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_EDIT = 8'h04;
  localparam logic [7:0] OFS_STORED = 8'h08;
  localparam logic [7:0] OFS_START = 8'h0C;
  localparam logic [7:0] OFS_SCREEN = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Field positions
  localparam int START_PEND_STEP_LSB = 0;
  localparam int START_PEND_PAT_LSB = 8;
  localparam int START_STEP_LSB = 16;
  localparam int START_PAT_LSB = 24;
  localparam int SCR_IDX_LSB = 0;
  localparam int SCR_GROUP_LSB = 8;
  localparam int STAT_STEP_FLD_LSB = 20;
  // Reset values and limits
  localparam logic [15:0] EDIT_RST = 16'h0000;
  localparam logic [4:0] START_RST = 5'h01;
  localparam logic [4:0] STEP_MAX = 5'h14;
  localparam logic [4:0] PAT_MAX = 5'h14;
  localparam logic [2:0] GROUP_LAST = 3'h7;
  localparam logic [3:0] SCR_LAST = 4'hF;
  localparam logic [3:0] COMBO_SCR_FIRST = 4'h1;
  localparam logic [3:0] COMBO_SCR_LAST = 4'h6;
  // ****************************************
  // Key and lamp indices
  // ****************************************
  localparam int KEY_N = 7;
  localparam int KEY_DOWN = 0;
  localparam int KEY_UP = 1;
  localparam int KEY_COMMIT = 2;
  localparam int KEY_PAT = 3;
  localparam int KEY_STEP = 4;
  localparam int KEY_GROUP = 5;
  localparam int KEY_SCREEN = 6;
  localparam int LAMP_N = 18;
  localparam int LAMP_RUN = 0;
  localparam int LAMP_PAUSE = 1;
  localparam int LAMP_HAND = 2;
  localparam int LAMP_FIX = 3;
  localparam int LAMP_PAT_IN = 4;
  localparam int LAMP_LINK = 5;
  localparam int LAMP_TUNE = 6;
  localparam int LAMP_OPEN = 7;
  localparam int LAMP_CLOSE = 8;
  localparam int LAMP_EV_LSB = 9;
  localparam int LAMP_XOUT_LSB = 12;
  localparam int LAMP_MV_ERR = 17;
  // Step field display modes
  typedef enum logic [1:0] {STEP_SHOW_NUM, STEP_SHOW_DASH, STEP_SHOW_BLANK} step_field_t;
endpackage

// ### verilog/key_edge.sv
/*
  Rising-edge detector for a group of front keys.
  Assumes key levels are already debounced and synchronous to the clock.
*/
`timescale 1ns/100ps
module key_edge #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Key levels and their press pulses
  input wire logic [W-1:0] level_i,
  output logic [W-1:0] rise_o
);
  logic [W-1:0] prev_r; // Level seen one cycle earlier

  // Remember last level
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev_r <= '0;
    end else begin
      prev_r <= level_i;
    end
  end

  // Press is high now, low before
  assign rise_o = level_i & ~prev_r;
endmodule

// ### verilog/blink_timebase.sv
/*
  Shared blink phase generator: toggles every HALF_CYC clock cycles.
  Assumes one instance feeds every blinking lamp so they stay in phase.
*/
`timescale 1ns/100ps
module blink_timebase #(
  parameter int HALF_CYC = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Blink phase
  output logic phase_o
);
  logic [31:0] cnt_r; // Cycles into the current half period

  // Count a half period, then flip the phase
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= 32'h0000_0000;
      phase_o <= 1'b0;
    end else if (cnt_r == 32'(HALF_CYC - 1)) begin
      cnt_r <= 32'h0000_0000;
      phase_o <= ~phase_o;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end
endmodule

// ### verification/operator_model.sv
/*
  Operator model: presses and releases front keys as clean levels.
  Assumes keys are sampled on the rising clock edge and already debounced.
*/
`timescale 1ns/100ps
module operator_model (
  // Clock
  input wire logic clk_i,
  // Key levels, high while pressed
  output logic [lamp_key_pkg::KEY_N-1:0] key_o
);
  // All keys rest released
  initial key_o = '0;
  // Hold a set of keys for some cycles, then release and pause
  task automatic press(input logic [6:0] mask, input int hold);
    key_o <= mask;
    repeat (hold) @(posedge clk_i);
    key_o <= '0;
    repeat (2) @(posedge clk_i);
  endtask
endmodule

// ### verification/testbench.sv
/*
  Self-checking bench for the panel lamp and key block.
  Assumes AXI ready lines of the master held high and a short blink period.
*/
`timescale 1ns/100ps
module testbench;
  import lamp_key_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic clk, rst_b, awv, wv, arv, awr, wr_rdy, bv, arr, rv, om, cm, hold, skip;
  logic [3:0] ws; // Write byte strobes
  logic [20:0] st; // Controller state bundle
  logic [6:0] key;
  logic [17:0] lamp; // Lamp image
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat, d;
  logic [1:0] bresp, rresp, r;
  logic [2:0] sgroup;
  logic [3:0] idx;
  logic [4:0] sstep, sptn;
  logic [15:0] edv;
  step_field_t sf;
  int failures, n_compared, cyc, n_hold, n_skip, cnt, ph;
  // Clock at 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  operator_model op (.clk_i(clk), .key_o(key));
  panel_lamp_key #(.BLINK_HALF_CYC(4)) dut (
    .CORE_CLK_I(clk), .RST_B_I(rst_b), .CTRL_RUN_I(st[0]), .START_DELAY_I(st[1]),
    .PAUSE_I(st[2]), .ERR_PAUSE_I(st[3]), .MANUAL_I(st[4]), .FIX_MODE_I(st[5]),
    .PAT_BY_INPUTS_I(st[6]), .LINK_MODE_I(st[7]), .TUNE_STANDBY_I(st[8]),
    .TUNE_EXEC_I(st[9]), .INPUT_ERR_I(st[10]), .CTRL_OPEN_I(st[11]), .CTRL_CLOSE_I(st[12]),
    .EVENT_I(st[15:13]), .EXTERNAL_OUT_I(st[20:16]), .KEY_I(key),
    .RUN_LAMP_O(lamp[0]), .PAUSE_LAMP_O(lamp[1]), .HAND_OPERATION_LAMP_O(lamp[2]),
    .FIX_LAMP_O(lamp[3]), .PATTERN_BY_INPUTS_LAMP_O(lamp[4]), .LINK_MODE_LAMP_O(lamp[5]),
    .SELF_TUNING_LAMP_O(lamp[6]), .OPEN_LAMP_O(lamp[7]), .CLOSE_LAMP_O(lamp[8]),
    .EVENT_LAMP_O(lamp[11:9]), .EXTERNAL_OUTPUT_LAMP_O(lamp[16:12]), .MV_SHOW_ERR_O(lamp[17]),
    .OPEN_MOTOR_O(om), .CLOSE_MOTOR_O(cm), .HOLD_OP_O(hold), .STEP_ADVANCE_OP_O(skip),
    .STEP_FIELD_O(sf), .SCREEN_GROUP_O(sgroup), .SCREEN_INDEX_O(idx), .START_STEP_O(sstep),
    .START_PAT_O(sptn), .EDIT_VALUE_O(edv), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wr_rdy), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(1'b1),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdat),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(1'b1));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // AXI write: both channels offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end while (!bv);
    resp = bresp;
  endtask
  // AXI read
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    v = rdat;
    resp = rresp;
  endtask
  // Counts, verdict and end of run
  task tally_and_finish;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Operation pulse counters and hang guard
  always @(posedge clk) begin
    n_hold <= n_hold + int'(hold === 1'b1);
    n_skip <= n_skip + int'(skip === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      tally_and_finish;
    end
  end
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    {rst_b, awv, wv, arv, awa, ara, wd, st} = '0;
    {cyc, n_hold, n_skip, failures, n_compared} = '0;
    ws = 4'hF;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    chk(sstep, 1);
    chk(lamp, 0);
    // Steady lamps, motor mirror and error display
    st <= 21'h0AADC1;
    repeat (3) @(posedge clk);
    chk(lamp, 18'h2AAF1);
    rd(OFS_STATUS, d, r);
    chk(d & 32'h33FFFF, 32'h2AAF1);
    st <= 21'h4;
    repeat (3) @(posedge clk);
    chk(lamp, 18'h2);
    st <= 21'h20;
    repeat (3) @(posedge clk);
    chk({sf, lamp}, {STEP_SHOW_DASH, 18'h8});
    st <= 21'h21;
    repeat (3) @(posedge clk);
    chk(sf, STEP_SHOW_BLANK);
    // Blinking lamps share one phase
    st <= 21'h21A;
    repeat (3) @(posedge clk);
    {cnt, ph} = '0;
    repeat (16) begin
      @(posedge clk);
      cnt += int'(lamp[0] === 1'b1);
      if (lamp[2:0] !== {3{lamp[0]}} || lamp[6] !== lamp[0]) ph++;
    end
    chk(cnt, 8);
    chk(ph, 0);
    // Manual motor drive by up and down keys
    st <= 21'h10;
    for (int k = 0; k < 2; k++) begin
      fork
        op.press(7'(1 << k), 4);
        begin
          repeat (3) @(posedge clk);
          chk({om, cm}, k ? 2'b10 : 2'b01);
        end
      join
    end
    // Up and down edit the pending value outside manual
    st <= 21'h0;
    op.press(7'h02, 2);
    rd(OFS_EDIT, d, r);
    chk(d, 1);
    op.press(7'h01, 2);
    rd(OFS_EDIT, d, r);
    chk(d, 0);
    // Pending start numbers and edit value adopted on commit
    op.press(7'h10, 2);
    op.press(7'h10, 2);
    op.press(7'h08, 2);
    wr(OFS_EDIT, 32'h1234, r);
    rd(OFS_START, d, r);
    chk(d, 32'h01010203);
    chk(edv, 0);
    op.press(7'h04, 2);
    chk({sstep, sptn, edv}, {5'h03, 5'h02, 16'h1234});
    // Unmapped and read-only accesses
    rd(8'h40, d, r);
    chk(r, RESP_DECERR);
    wr(8'h40, 0, r);
    chk(r, RESP_DECERR);
    wr(OFS_STORED, 0, r);
    rd(OFS_STORED, d, r);
    chk(r, RESP_OKAY);
    chk(d, 32'h1234);
    // Low byte lane only reaches the pending value
    ws <= 4'h1;
    wr(OFS_EDIT, 32'h5678, r);
    ws <= 4'hF;
    rd(OFS_EDIT, d, r);
    chk(d, 32'h1278);
    // Key combinations on screen 0-1, then group change
    op.press(7'h40, 2);
    op.press(7'h0C, 2);
    op.press(7'h14, 2);
    chk({idx, n_hold[3:0], n_skip[3:0]}, 12'h111);
    op.press(7'h20, 2);
    chk({sgroup, idx}, 7'h10);
    op.press(7'h0C, 2);
    chk(n_hold, 1);
    tally_and_finish;
  end
endmodule
